// file: qlp_params.svh
/*
  constants of the quad-port pixel link: geometry, slot timing, strap capture.
  assumes a 125 MHz system clock on both ends of the link.
*/
`ifndef QLP_PARAMS_SVH
`define QLP_PARAMS_SVH
`define QLP_PORTS 4
`define QLP_LANES 4
`define QLP_SLOTS 7
`define QLP_COLOR_BITS 8
`define QLP_MCLK_PERIOD_NS 8
`define QLP_SLOT_NS 32
`define QLP_SLOT_CYC (`QLP_SLOT_NS / `QLP_MCLK_PERIOD_NS)
`define QLP_SAMPLE_OFS (`QLP_SLOT_CYC / 2)
`define QLP_CLK_HIGH_SLOTS 4
`define QLP_STRAP_WAIT 8
`define QLP_MAP_RESET 1'b1
`endif

// file: qlp_pkg.sv
/*
  types and lane map functions shared by both ends of the pixel link.
  assumes qlp_params.svh is on the include path.
*/
`include "qlp_params.svh"
package qlp_pkg;
  typedef logic [`QLP_COLOR_BITS-1:0] qlp_color_t;
  typedef logic [`QLP_SLOTS-1:0] qlp_slots_t;
  typedef qlp_slots_t [`QLP_LANES-1:0] qlp_word_t;
  typedef logic [`QLP_LANES-1:0] qlp_lanes_t;
  typedef logic [2:0] qlp_cnt_t;
  typedef struct packed {
    qlp_color_t red;
    qlp_color_t green;
    qlp_color_t blue;
    logic hsync;
    logic vsync;
    logic display_enable;
  } qlp_pixel_s;
  localparam qlp_cnt_t QLP_SLOT_LAST = 3'(`QLP_SLOTS - 1);
  localparam qlp_cnt_t QLP_SLOT_IDLE = 3'(`QLP_SLOTS);
  localparam qlp_cnt_t QLP_CYC_LAST = 3'(`QLP_SLOT_CYC - 1);
  localparam qlp_cnt_t QLP_CYC_SAMPLE = 3'(`QLP_SAMPLE_OFS);
  localparam qlp_cnt_t QLP_CLK_HIGH = 3'(`QLP_CLK_HIGH_SLOTS);
  localparam qlp_cnt_t QLP_STRAP_LAST = 3'(`QLP_STRAP_WAIT - 1);

  // pixel to lane words; slot n of a lane is bit n of its word
  function automatic qlp_word_t qlp_pack(input qlp_pixel_s p, input logic map_high);
    qlp_word_t w;
    if (map_high) begin
      w[0] = {p.green[2], p.red[7:2]}; // R04
      w[1] = {p.blue[3:2], p.green[7:3]}; // R05
      w[2] = {p.display_enable, p.vsync, p.hsync, p.blue[7:4]}; // R06
      w[3] = {1'b0, p.blue[1:0], p.green[1:0], p.red[1:0]}; // R07
    end else begin
      w[0] = {p.green[0], p.red[5:0]}; // R04
      w[1] = {p.blue[1:0], p.green[5:1]}; // R05
      w[2] = {p.display_enable, p.vsync, p.hsync, p.blue[5:2]}; // R06
      w[3] = {1'b0, p.blue[7:6], p.green[7:6], p.red[7:6]}; // R07
    end
    return w;
  endfunction : qlp_pack

  // lane words back to a pixel; lane 3 slot 6 is ignored
  function automatic qlp_pixel_s qlp_unpack(input qlp_word_t w, input logic map_high);
    qlp_pixel_s p;
    p.hsync = w[2][4]; // R06
    p.vsync = w[2][5]; // R06
    p.display_enable = w[2][6]; // R06
    if (map_high) begin
      p.red = {w[0][5:0], w[3][1:0]}; // R04
      p.green = {w[1][4:0], w[0][6], w[3][3:2]}; // R05
      p.blue = {w[2][3:0], w[1][6:5], w[3][5:4]}; // R07
    end else begin
      p.red = {w[3][1:0], w[0][5:0]}; // R04
      p.green = {w[3][3:2], w[1][4:0], w[0][6]}; // R05
      p.blue = {w[3][5:4], w[2][3:0], w[1][6:5]}; // R07
    end
    return p;
  endfunction : qlp_unpack
endpackage : qlp_pkg

// file: qlp_link_if.sv
/*
  the four-port pixel link between host transmitter and panel receiver.
  assumes the strap has a pull-up: undriven it reads high.
*/
`include "qlp_params.svh"
interface qlp_link_if;
  import qlp_pkg::*;
  logic [`QLP_PORTS-1:0] clock_pair; // one pixel clock per port
  qlp_lanes_t [`QLP_PORTS-1:0] lane; // four data lanes per port
  logic strap_out; // level host would drive
  logic strap_oe_n; // low while host drives strap
  logic map_select_strap; // resolved strap level
  // open strap floats high through the pull-up
  assign map_select_strap = strap_oe_n ? 1'b1 : strap_out;
  modport host (output clock_pair, output lane, output strap_out, output strap_oe_n);
  modport dev (input clock_pair, input lane, input map_select_strap);
endinterface : qlp_link_if

// file: qlp_lane_unmap.sv
/*
  turns one port's collected lane words into a registered pixel.
  assumes load_in is a one-cycle pulse after the last slot is sampled.
*/
`include "qlp_params.svh"
module qlp_lane_unmap
  import qlp_pkg::*;
(
  input wire logic mclk_in, // system clock
  input wire logic rst_in, // async reset, active high
  input qlp_pkg::qlp_word_t word_in, // sampled slots
  input wire logic load_in, // word complete
  input wire logic map_high_in, // selected map
  output qlp_pkg::qlp_pixel_s pixel_out, // decoded pixel
  output logic valid_out // pixel strobe
);
  import qlp_pkg::*;
  qlp_pixel_s next_pixel;
  logic next_valid;

  // colour bits pass straight through: 8 bits, 0 low, 1 high
  always_comb begin
    next_pixel = pixel_out;
    next_valid = load_in;
    if (load_in) begin
      next_pixel = qlp_unpack(word_in, map_high_in); // R09 R10
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pixel_out <= '0;
      valid_out <= 1'b0;
    end else begin
      pixel_out <= next_pixel;
      valid_out <= next_valid;
    end
  end
endmodule : qlp_lane_unmap

// file: qlp_panel_rx.sv
/*
  panel end of the quad-port pixel link: strap capture, per-port clock
  recovery by oversampling, slot sampling and pixel decode.
  assumes the host sends seven slots of a fixed length per pixel clock,
  with the clock rising at slot 0, and holds the strap still while powered.
  lock status is advisory only: pixels still come out while unlocked,
  so a user that needs clean frames must qualify them with locked_out.
  ports are decoded independently; no alignment across ports is done.
  the strap is taken once; a later change shows only after a reset.
*/
// Functional notes
// R01: strap high picks msb-split, low lsb-split
// R02: host selects high map by leaving strap open
// R03: strap must not change while powered
// R04: lane 0 carries red and green low
// R05: lane 1 carries green and blue
// R06: lane 2 carries blue, syncs, enable
// R07: lane 3 carries remaining colour bits
// R08: each port own clock, same lane map
// R09: each colour is an 8-bit intensity
// R10: all zero is black, all one full
// R11: host keeps line jitter within one clock
// R12: host sends syncs alike on all ports
`include "qlp_params.svh"

module qlp_panel_rx
  import qlp_pkg::*;
(
  input wire logic mclk_in, // system clock
  input wire logic rst_in, // async reset, active high
  qlp_link_if.dev link, // pixel link from host
  output qlp_pkg::qlp_pixel_s [`QLP_PORTS-1:0] pixel_out, // decoded pixels
  output logic [`QLP_PORTS-1:0] pixel_valid_out, // one-cycle pixel strobes
  output logic [`QLP_PORTS-1:0] locked_out, // clock seen on schedule
  output logic map_high_out // map in use
);
  import qlp_pkg::*;

  // strap state
  logic strap_s1;
  logic strap_s2;
  logic map_high;
  logic map_taken;
  qlp_cnt_t strap_cnt;

  // next values of the strap state
  logic next_map_high;
  logic next_map_taken;
  qlp_cnt_t next_strap_cnt;

  // strap synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1 <= `QLP_MAP_RESET;
      strap_s2 <= `QLP_MAP_RESET;
    end else begin
      strap_s1 <= link.map_select_strap;
      strap_s2 <= strap_s1;
    end
  end

  // take the strap once, after the host has had time to settle it;
  // later changes are ignored since the host may not make them
  always_comb begin
    next_map_high = map_high;
    next_map_taken = map_taken;
    next_strap_cnt = strap_cnt;
    if (!map_taken) begin
      if (strap_cnt == QLP_STRAP_LAST) begin
        next_map_high = strap_s2; // R01 R02
        next_map_taken = 1'b1; // R03
      end else begin
        next_strap_cnt = strap_cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      map_high <= `QLP_MAP_RESET;
      map_taken <= 1'b0;
      strap_cnt <= '0;
    end else begin
      map_high <= next_map_high;
      map_taken <= next_map_taken;
      strap_cnt <= next_strap_cnt;
    end
  end

  // reported so a host can confirm the strap it left open or drove
  assign map_high_out = map_high;

  // per-port receive state
  logic [`QLP_PORTS-1:0] clk_s1;
  logic [`QLP_PORTS-1:0] clk_s2;
  logic [`QLP_PORTS-1:0] clk_s3;
  qlp_lanes_t [`QLP_PORTS-1:0] lane_s1;
  qlp_lanes_t [`QLP_PORTS-1:0] lane_s2;
  qlp_cnt_t [`QLP_PORTS-1:0] slot;
  qlp_cnt_t [`QLP_PORTS-1:0] cyc;
  qlp_word_t [`QLP_PORTS-1:0] word;
  logic [`QLP_PORTS-1:0] load;
  logic [`QLP_PORTS-1:0] locked;

  // next values of the per-port state
  qlp_cnt_t [`QLP_PORTS-1:0] next_slot;
  qlp_cnt_t [`QLP_PORTS-1:0] next_cyc;
  qlp_word_t [`QLP_PORTS-1:0] next_word;
  logic [`QLP_PORTS-1:0] next_load;
  logic [`QLP_PORTS-1:0] next_locked;

  // every port recovers its own clock; ports may be skewed against
  // each other, so no port borrows timing from another
  genvar gp;
  generate
    for (gp = 0; gp < `QLP_PORTS; gp++) begin : g_port
      logic rise;

      // two-stage synchronisers for clock and lanes
      // lanes need no handshake: each level stands for a whole slot
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          clk_s1[gp] <= 1'b0;
          clk_s2[gp] <= 1'b0;
          clk_s3[gp] <= 1'b0;
          lane_s1[gp] <= '0;
          lane_s2[gp] <= '0;
        end else begin
          clk_s1[gp] <= link.clock_pair[gp]; // R08
          clk_s2[gp] <= clk_s1[gp];
          clk_s3[gp] <= clk_s2[gp];
          lane_s1[gp] <= link.lane[gp];
          lane_s2[gp] <= lane_s1[gp];
        end
      end

      // lanes and clock share the same delay, so slot 0 starts on the rise
      // a synchronised level needs one more stage to find its edge
      assign rise = clk_s2[gp] & ~clk_s3[gp];

      // slot timing: sample each lane in the middle of every slot
      // the middle of a slot is furthest from both lane transitions
      always_comb begin
        next_slot[gp] = slot[gp];
        next_cyc[gp] = cyc[gp];
        next_word[gp] = word[gp];
        next_load[gp] = 1'b0;
        next_locked[gp] = locked[gp];
        if (rise) begin
          next_slot[gp] = '0;
          next_cyc[gp] = 3'd1;
          // on schedule, the rise lands in the first cycle after slot 6;
          // a parked port has moved its count away from zero by then
          next_locked[gp] = (slot[gp] == QLP_SLOT_IDLE) && (cyc[gp] == '0);
        end else if (slot[gp] != QLP_SLOT_IDLE) begin
          if (cyc[gp] == QLP_CYC_SAMPLE) begin
            for (int l = 0; l < `QLP_LANES; l++) begin
              next_word[gp][l][slot[gp]] = lane_s2[gp][l]; // R04 R05 R06 R07 R08
            end
            next_load[gp] = (slot[gp] == QLP_SLOT_LAST);
          end
          if (cyc[gp] == QLP_CYC_LAST) begin
            next_cyc[gp] = '0;
            next_slot[gp] = slot[gp] + 3'd1;
          end else begin
            next_cyc[gp] = cyc[gp] + 3'd1;
          end
        end else begin
          // clock missing: park until the next rise; the non-zero count
          // tells a late rise apart from one that is on schedule
          next_cyc[gp] = QLP_CYC_LAST;
          next_locked[gp] = 1'b0;
        end
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          slot[gp] <= QLP_SLOT_IDLE;
          cyc[gp] <= '0;
          word[gp] <= '0;
          load[gp] <= 1'b0;
          locked[gp] <= 1'b0;
        end else begin
          slot[gp] <= next_slot[gp];
          cyc[gp] <= next_cyc[gp];
          word[gp] <= next_word[gp];
          load[gp] <= next_load[gp];
          locked[gp] <= next_locked[gp];
        end
      end

      // decode with the captured map, same for all ports
      // one common map means a late strap cannot split the ports
      qlp_lane_unmap u_unmap (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .word_in(word[gp]),
        .load_in(load[gp]),
        .map_high_in(map_high), // R01
        .pixel_out(pixel_out[gp]),
        .valid_out(pixel_valid_out[gp])
      );
    end
  endgenerate

  // lock is per port since each port has its own clock
  assign locked_out = locked;

endmodule : qlp_panel_rx

// file: qlp_host_tx.sv
/*
  host end of the quad-port pixel link: slot divider, pixel clocks,
  lane serialisers and strap drive.
  assumes the user holds pixel inputs valid whenever pixel_take_out pulses.
*/
`include "qlp_params.svh"
module qlp_host_tx
  import qlp_pkg::*;
(
  input wire logic mclk_in, // system clock
  input wire logic rst_in, // async reset, active high
  qlp_link_if.host link, // pixel link to panel
  input wire logic map_high_in, // map wanted, caught at reset release
  input qlp_pkg::qlp_color_t [`QLP_PORTS-1:0] red_in, // red per port
  input qlp_pkg::qlp_color_t [`QLP_PORTS-1:0] green_in, // green per port
  input qlp_pkg::qlp_color_t [`QLP_PORTS-1:0] blue_in, // blue per port
  input wire logic hsync_in, // horizontal sync, all ports
  input wire logic vsync_in, // vertical sync, all ports
  input wire logic display_enable_in, // enable, all ports
  output logic pixel_take_out // inputs taken this cycle
);
  import qlp_pkg::*;
  qlp_cnt_t div;
  qlp_cnt_t slot;
  qlp_word_t [`QLP_PORTS-1:0] word;
  logic map_high;
  logic map_taken;
  logic clk_o;
  qlp_lanes_t [`QLP_PORTS-1:0] lane_o;
  qlp_cnt_t next_div;
  qlp_cnt_t next_slot;
  qlp_word_t [`QLP_PORTS-1:0] next_word;
  logic next_map_high;
  logic next_map_taken;
  logic next_clk;
  qlp_lanes_t [`QLP_PORTS-1:0] next_lane;
  logic frame_start;
  qlp_pixel_s px;

  assign frame_start = (div == QLP_CYC_LAST) && (slot == QLP_SLOT_LAST);
  assign pixel_take_out = frame_start;

  // slot divider and serialisers; all ports load in the same cycle
  always_comb begin
    next_div = (div == QLP_CYC_LAST) ? '0 : div + 3'd1; // R11
    next_slot = slot;
    next_word = word;
    next_clk = clk_o;
    next_lane = lane_o;
    next_map_taken = 1'b1;
    next_map_high = map_taken ? map_high : map_high_in; // R03
    px = '0;
    if (div == QLP_CYC_LAST) begin
      next_slot = frame_start ? '0 : slot + 3'd1;
      next_clk = (next_slot < QLP_CLK_HIGH); // R08
      for (int p = 0; p < `QLP_PORTS; p++) begin
        if (frame_start) begin
          px.red = red_in[p];
          px.green = green_in[p];
          px.blue = blue_in[p];
          px.hsync = hsync_in; // R12
          px.vsync = vsync_in; // R12
          px.display_enable = display_enable_in; // R12
          next_word[p] = qlp_pack(px, map_high); // R04 R05 R06 R07 R08
        end
        for (int l = 0; l < `QLP_LANES; l++) begin
          next_lane[p][l] = next_word[p][l][next_slot];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= '0;
      slot <= QLP_SLOT_LAST;
      word <= '0;
      map_high <= `QLP_MAP_RESET;
      map_taken <= 1'b0;
      clk_o <= 1'b0;
      lane_o <= '0;
    end else begin
      div <= next_div;
      slot <= next_slot;
      word <= next_word;
      map_high <= next_map_high;
      map_taken <= next_map_taken;
      clk_o <= next_clk;
      lane_o <= next_lane;
    end
  end

  assign link.clock_pair = {`QLP_PORTS{clk_o}};
  assign link.lane = lane_o;
  // high map leaves the strap open; only the low map drives it
  assign link.strap_out = 1'b0; // R01
  assign link.strap_oe_n = map_high; // R02
endmodule : qlp_host_tx

// file: qlp_link_properties.sv
/*
  wire-level checks of the quad-port pixel link between the two ends.
  assumes both ends share mclk_in and the host makes the link clock.
*/
`include "qlp_params.svh"
module qlp_link_properties
  import qlp_pkg::*;
(
  input wire logic mclk_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic [`QLP_PORTS-1:0] clock_pair, // pixel clocks
  input wire qlp_pkg::qlp_lanes_t [`QLP_PORTS-1:0] lane, // data lanes
  input wire logic strap_out, // host strap level
  input wire logic strap_oe_n, // low while host drives strap
  input wire logic map_select_strap // resolved strap
);
  import qlp_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic ck;
  logic alike;
  // port 0 stands for all clocks; a separate check ties the others to it
  assign ck = clock_pair[0];
  assign alike = lane[0][2] == lane[1][2] && lane[1][2] == lane[2][2] && lane[2][2] == lane[3][2];

  // two edges of grace after release while the strap drive settles
  property p_strap_fixed;
    !$past(rst_in) && !$past(rst_in, 2) |-> $stable(strap_oe_n) && $stable(map_select_strap);
  endproperty
  property p_strap_low_only;
    !strap_oe_n |-> !strap_out;
  endproperty
  property p_clk_high;
    $rose(ck) |-> ck [*8] ##1 ck [*8] ##1 !ck;
  endproperty
  property p_clk_low;
    $fell(ck) |-> !ck [*8] ##1 !ck [*4] ##1 ck;
  endproperty
  property p_ports_one_clock;
    clock_pair == {`QLP_PORTS{ck}};
  endproperty
  property p_slot_hold;
    $rose(ck) |-> ##1 $stable(lane) [*3] ##2 $stable(lane) [*3];
  endproperty
  property p_lane3_spare;
    $rose(ck) |-> ##24 (!(lane[0][3] | lane[1][3] | lane[2][3] | lane[3][3])) [*4];
  endproperty
  property p_sync_alike;
    $rose(ck) |-> ##16 alike [*8] ##1 alike [*4];
  endproperty

  a_strap_fixed: assert property (p_strap_fixed) else $error("strap moved");
  a_strap_low_only: assert property (p_strap_low_only) else $error("strap driven high");
  a_clk_high: assert property (p_clk_high) else $error("clock high length");
  a_clk_low: assert property (p_clk_low) else $error("clock low length");
  a_ports_one_clock: assert property (p_ports_one_clock) else $error("port clocks differ");
  a_slot_hold: assert property (p_slot_hold) else $error("slot not held");
  a_lane3_spare: assert property (p_lane3_spare) else $error("spare slot used");
  a_sync_alike: assert property (p_sync_alike) else $error("syncs differ");

  // main scenarios
  c_pixel: cover property ($rose(ck));
  c_low_map: cover property (!strap_oe_n);
  c_sync: cover property ($rose(lane[0][2]) ##1 alike);
endmodule : qlp_link_properties

// file: quad_lvds_pixel_input_map_tb.sv
/*
  testbench: host end feeds panel end over the link, both maps in turn.
  assumes pixel inputs are taken while pixel_take_out is high.
*/
`include "qlp_params.svh"
module quad_lvds_pixel_input_map_tb;
  import qlp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic map_high_in = 1'b1;
  qlp_color_t [`QLP_PORTS-1:0] red_in = '0;
  qlp_color_t [`QLP_PORTS-1:0] green_in = '0;
  qlp_color_t [`QLP_PORTS-1:0] blue_in = '0;
  logic hsync_in = 1'b0;
  logic vsync_in = 1'b0;
  logic display_enable_in = 1'b0;
  logic pixel_take_out;
  qlp_pixel_s [`QLP_PORTS-1:0] pixel_out;
  logic [`QLP_PORTS-1:0] pixel_valid_out;
  logic [`QLP_PORTS-1:0] locked_out;
  logic map_high_out;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int got [4];
  qlp_pixel_s exp_q [4][$];
  qlp_word_t seen_w [4];

  qlp_link_if link();
  qlp_host_tx u_qlp_host_tx (.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
    .map_high_in(map_high_in), .red_in(red_in), .green_in(green_in), .blue_in(blue_in),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .display_enable_in(display_enable_in),
    .pixel_take_out(pixel_take_out));
  qlp_panel_rx u_qlp_panel_rx (.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
    .pixel_out(pixel_out), .pixel_valid_out(pixel_valid_out), .locked_out(locked_out),
    .map_high_out(map_high_out));
  qlp_link_properties u_qlp_link_properties (.mclk_in(mclk_in), .rst_in(rst_in),
    .clock_pair(link.clock_pair), .lane(link.lane), .strap_out(link.strap_out),
    .strap_oe_n(link.strap_oe_n), .map_select_strap(link.map_select_strap));

  initial begin
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // wire word worked out slot by slot from the two bit maps
  function automatic qlp_word_t mk_word(input qlp_pixel_s x, input logic hi);
    qlp_word_t w;
    if (hi) begin
      w[0] = {x.green[2], x.red[7:2]};
      w[1] = {x.blue[3:2], x.green[7:3]};
      w[2] = {x.display_enable, x.vsync, x.hsync, x.blue[7:4]};
      w[3] = {1'b0, x.blue[1:0], x.green[1:0], x.red[1:0]};
    end else begin
      w[0] = {x.green[0], x.red[5:0]};
      w[1] = {x.blue[1:0], x.green[5:1]};
      w[2] = {x.display_enable, x.vsync, x.hsync, x.blue[5:2]};
      w[3] = {1'b0, x.blue[7:6], x.green[7:6], x.red[7:6]};
    end
    return w;
  endfunction : mk_word

  function automatic qlp_pixel_s cur_px(input int p);
    return {red_in[p], green_in[p], blue_in[p], hsync_in, vsync_in, display_enable_in};
  endfunction : cur_px

  // basic colours first, then patterns that differ per port
  task automatic set_pix(input int k);
    logic [23:0] c;
    for (int p = 0; p < 4; p++) begin
      case (k)
        0: c = 24'h000000;
        1: c = 24'hffffff;
        2: c = 24'hff0000;
        3: c = 24'hff00ff;
        4: c = 24'h00ff00;
        5: c = 24'h0000ff;
        default: c = 24'(k * 24'h2f1e37 + p * 24'h0b0d17);
      endcase
      {red_in[p], green_in[p], blue_in[p]} = c;
    end
    hsync_in = k[0];
    vsync_in = k[1];
    display_enable_in = !k[2];
  endtask : set_pix

  task automatic run_map(input logic hi);
    int n;
    rst_in = 1'b1;
    map_high_in = hi;
    for (int p = 0; p < 4; p++) begin
      exp_q[p].delete();
      got[p] = 0;
    end
    repeat (20) @(negedge mclk_in);
    rst_in = 1'b0;
    for (int k = 0; k < 10; k++) begin
      set_pix(k);
      n = 0;
      while (pixel_take_out !== 1'b1 && n < 100) begin
        @(negedge mclk_in);
        n++;
      end
      // a late change of the wanted map must not reach the wire
      if (k == 1) map_high_in = !hi;
      for (int s = 0; s < 7; s++) begin
        repeat ((s == 0) ? 1 : 4) @(negedge mclk_in);
        check(32'(link.clock_pair), (s < 4) ? 32'hf : 32'h0);
        for (int p = 0; p < 4; p++)
          for (int l = 0; l < 4; l++) seen_w[p][l][s] = link.lane[p][l];
      end
      for (int p = 0; p < 4; p++) check(32'(seen_w[p]), 32'(mk_word(cur_px(p), hi)));
    end
    repeat (40) @(negedge mclk_in);
    for (int p = 0; p < 4; p++) check(32'(got[p] >= 10), 32'h1);
    check(32'(locked_out), 32'hf);
    check(32'(map_high_out), 32'(hi));
    check(32'(link.map_select_strap), 32'(hi));
  endtask : run_map

  // every taken pixel must come out of its own port unchanged
  always @(negedge mclk_in) begin
    logic [31:0] e;
    if (rst_in === 1'b0) begin
      if (pixel_take_out === 1'b1)
        for (int p = 0; p < 4; p++) exp_q[p].push_back(cur_px(p));
      for (int p = 0; p < 4; p++) begin
        if (pixel_valid_out[p] === 1'b1) begin
          e = (exp_q[p].size() != 0) ? 32'(exp_q[p].pop_front()) : 32'hffffffff;
          check(32'(pixel_out[p]), e);
          got[p]++;
        end
      end
    end
  end

  // hang guard, well above two runs of about 340 cycles each
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    @(negedge mclk_in);
    run_map(1'b1);
    run_map(1'b0);
    wrap_up();
  end
endmodule : quad_lvds_pixel_input_map_tb
